// ---- core/agc_regs_pkg.sv ----
/*
 * Constants for the amplifier control register bank: serial addresses,
 * register map, reset values, writable masks and step timing.
 * Assumes a 25 MHz core clock; the serial interface is sampled in that clock.
 */
// Overview of operation
// - Answer serial address B0 write, B1 read
// - Registers one to seven reset to defaults
// - Addresses above seven: writes ignored, reads zero
// - Enable bit six makes amplifier channel active
// - Thermal shutdown overrides enable, resumes when cool
// - Soft shutdown bit five stops control, bias, oscillator
// - Short flag bit three latches until zero written
// - Thermal flag bit two deglitched, latched, write-zero clears
// - Noise gate bit zero, only if ratio not 1:1
// - Write pointer from first byte, then increments
// - Enable pin low resets registers and logic, not the pin samplers
// - Release interval is code times 0.0137 s
package agc_regs_pkg;

   // ----------------------------------------------------------------
   // serial addressing
   // ----------------------------------------------------------------
   localparam logic [7:0] DEV_ADDR_WR = 8'hB0;
   localparam logic [7:0] DEV_ADDR_RD = 8'hB1;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_FIRST          = 8'h01;
   localparam logic [7:0] REG_LAST           = 8'h07;
   localparam int         NUM_REGS           = 7;
   localparam logic [7:0] ADDR_FUNC_CTRL     = 8'h01;
   localparam logic [7:0] ADDR_ATTACK        = 8'h02;
   localparam logic [7:0] ADDR_RELEASE       = 8'h03;
   localparam logic [7:0] ADDR_HOLD          = 8'h04;
   localparam logic [7:0] ADDR_FIXED_GAIN    = 8'h05;
   localparam logic [7:0] ADDR_LIMITER_GATE  = 8'h06;
   localparam logic [7:0] ADDR_MAXGAIN_RATIO = 8'h07;

   // reset values, index 0 is register 1
   localparam logic [7:0] REG_DEFAULT [NUM_REGS] =
      '{8'hC3, 8'h05, 8'h0B, 8'h00, 8'h06, 8'h3A, 8'hC2};
   // bits a host write may change; flags handled separately
   localparam logic [7:0] REG_WMASK [NUM_REGS] =
      '{8'h61, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'hFF, 8'hF3};

   // function control fields
   localparam int BIT_AMP_EN        = 6;
   localparam int BIT_SOFT_SHUTDOWN = 5;
   localparam int BIT_SHORT_FLAG    = 3;
   localparam int BIT_THERMAL_FLAG  = 2;
   localparam int BIT_NOISE_GATE_ON = 0;
   localparam int CODE_MSB          = 5;
   localparam logic [1:0] RATIO_ONE_TO_ONE = 2'h0;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam real CLK_MHZ         = 25.0;
   localparam real ATTACK_STEP_MS  = 0.1067;
   localparam real RELEASE_STEP_S  = 0.0137;
   localparam int  ATTACK_UNIT_CYC = int'($ceil(ATTACK_STEP_MS * 1000.0 * CLK_MHZ));
   localparam int  RELEASE_UNIT_CYC = int'($ceil(RELEASE_STEP_S * 1000000.0 * CLK_MHZ));
   localparam int  THERM_DEGLITCH_CYC = 16;
   localparam int  UNIT_CNT_W      = 20;

endpackage

// ---- core/agc_amp_control_registers.sv ----
/*
 * Control and status register bank with its serial slave.
 * Assumes scl/sda inputs already synchronous to clk, an external
 * open-drain pad resolving sdaOut/sdaOe, and analog-side fault inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module agc_amp_control_registers
   import agc_regs_pkg::*;
#(
   parameter int RELEASE_UNIT = RELEASE_UNIT_CYC,
   parameter int ATTACK_UNIT  = ATTACK_UNIT_CYC,
   parameter int DEGLITCH     = THERM_DEGLITCH_CYC
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       hwEnable,
   // serial pins
   input  wire logic       scl,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   // analog status
   input  wire logic       shortDetect,
   input  wire logic       overTemp,
   // control outputs
   output logic            ampActive,
   output logic            coreRun,
   output logic            noiseGateActive,
   output logic [5:0]      attackStepCode,
   output logic [5:0]      releaseStepCode,
   output logic [5:0]      holdCode,
   output logic [5:0]      presetGainCode,
   output logic [7:0]      limiterGateCfg,
   output logic [7:0]      maxGainRatioCfg,
   output logic            attackTick,
   output logic            releaseTick
);

   // ----------------------------------------------------------------
   // reset and pin sampling
   // ----------------------------------------------------------------
   logic       clear;
   logic       sclPrev_r;
   logic       sdaPrev_r;
   logic       sclRise;
   logic       sclFall;
   logic       startCond;
   logic       stopCond;

   assign clear = !rst_n || !hwEnable;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end else begin
         sclPrev_r <= scl;
         sdaPrev_r <= sdaIn;
      end
   end

   assign sclRise   = scl && !sclPrev_r;
   assign sclFall   = !scl && sclPrev_r;
   assign startCond = scl && sclPrev_r && sdaPrev_r && !sdaIn;
   assign stopCond  = scl && sclPrev_r && !sdaPrev_r && sdaIn;

   // ----------------------------------------------------------------
   // serial slave
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK
   } slave_e;

   slave_e     state_r;
   slave_e     ackNext_r;
   logic [3:0] bitCnt_r;
   logic [7:0] shift_r;
   logic [7:0] ptr_r;
   logic [7:0] tx_r;
   logic       sdaDrive_r;
   logic       wrStb;
   logic [7:0] wrData;
   logic [7:0] rdData;
   logic [7:0] rxByte;
   logic [7:0] regFile [NUM_REGS];
   logic       shortFlag_r;
   logic       thermFlag_r;

   assign rxByte = {shift_r[6:0], sdaIn};

   // read mux; test space and address zero read as zero
   always_comb begin
      rdData = 8'h00;
      if (ptr_r >= REG_FIRST && ptr_r <= REG_LAST) begin
         rdData = regFile[3'(ptr_r - REG_FIRST)];
      end
      if (ptr_r == ADDR_FUNC_CTRL) begin
         rdData[BIT_SHORT_FLAG]   = shortFlag_r;
         rdData[BIT_THERMAL_FLAG] = thermFlag_r;
      end
   end

   always_ff @(posedge clk) begin
      if (clear) begin
         state_r    <= ST_IDLE;
         ackNext_r  <= ST_IDLE;
         bitCnt_r   <= 4'h0;
         shift_r    <= 8'h00;
         ptr_r      <= 8'h00;
         tx_r       <= 8'h00;
         sdaDrive_r <= 1'b0;
      end else if (startCond) begin
         // repeated start keeps the pointer for the read phase
         state_r    <= ST_ADDR;
         bitCnt_r   <= 4'h0;
         sdaDrive_r <= 1'b0;
      end else if (stopCond) begin
         state_r    <= ST_IDLE;
         sdaDrive_r <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
            end
            ST_ADDR, ST_REG, ST_WDATA: begin
               if (sclRise && bitCnt_r < 4'h8) begin
                  shift_r  <= rxByte;
                  bitCnt_r <= bitCnt_r + 4'h1;
               end else if (sclFall && bitCnt_r == 4'h8) begin
                  bitCnt_r <= 4'h0;
                  if (state_r == ST_ADDR) begin
                     if (shift_r == DEV_ADDR_WR) begin
                        sdaDrive_r <= 1'b1;
                        ackNext_r  <= ST_REG;
                        state_r    <= ST_ACK;
                     end else if (shift_r == DEV_ADDR_RD) begin
                        sdaDrive_r <= 1'b1;
                        tx_r       <= rdData;
                        ackNext_r  <= ST_RDATA;
                        state_r    <= ST_ACK;
                     end else begin
                        state_r <= ST_IDLE;
                     end
                  end else begin
                     if (state_r == ST_REG) begin
                        ptr_r <= shift_r;
                     end else begin
                        ptr_r <= ptr_r + 8'h01;
                     end
                     sdaDrive_r <= 1'b1;
                     ackNext_r  <= ST_WDATA;
                     state_r    <= ST_ACK;
                  end
               end
            end
            ST_ACK: begin
               if (sclFall) begin
                  state_r  <= ackNext_r;
                  bitCnt_r <= 4'h0;
                  // pointer has already moved at the ack rise, so fetch live
                  if (ackNext_r == ST_RDATA) begin
                     tx_r       <= rdData;
                     sdaDrive_r <= !rdData[7];
                  end else begin
                     sdaDrive_r <= 1'b0;
                  end
               end
            end
            ST_RDATA: begin
               if (sclFall) begin
                  if (bitCnt_r == 4'h7) begin
                     sdaDrive_r <= 1'b0;
                     state_r    <= ST_RACK;
                  end else begin
                     sdaDrive_r <= !tx_r[6];
                     tx_r       <= {tx_r[6:0], 1'b0};
                     bitCnt_r   <= bitCnt_r + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (sclRise) begin
                  if (sdaIn) begin
                     state_r <= ST_IDLE;
                  end else begin
                     ptr_r   <= ptr_r + 8'h01;
                     state_r <= ST_ACK;
                     ackNext_r <= ST_RDATA;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // data byte committed at its eighth falling edge, before the pointer moves
   assign wrStb  = !clear && !startCond && !stopCond && state_r == ST_WDATA
                   && sclFall && bitCnt_r == 4'h8;
   assign wrData = shift_r;
   assign sdaOut = 1'b0;
   assign sdaOe  = sdaDrive_r;

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   generate
      for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
         always_ff @(posedge clk) begin
            if (clear) begin
               regFile[i] <= REG_DEFAULT[i];
            end else if (wrStb && ptr_r == REG_FIRST + 8'(i)) begin
               // fixed bits keep their reset value
               regFile[i] <= (REG_DEFAULT[i] & ~REG_WMASK[i])
                             | (wrData & REG_WMASK[i]);
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // latched fault flags
   // ----------------------------------------------------------------
   logic       funcWr;
   logic [4:0] deglitch_r;
   logic       thermStable;

   assign funcWr = wrStb && ptr_r == ADDR_FUNC_CTRL;

   // overtemp must persist before it counts, so noise cannot trip it
   always_ff @(posedge clk) begin
      if (clear || !overTemp) begin
         deglitch_r <= 5'h00;
      end else if (!thermStable) begin
         deglitch_r <= deglitch_r + 5'h01;
      end
   end
   assign thermStable = deglitch_r >= 5'(DEGLITCH);

   // detection wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (clear) begin
         shortFlag_r <= 1'b0;
      end else if (shortDetect) begin
         shortFlag_r <= 1'b1;
      end else if (funcWr && !wrData[BIT_SHORT_FLAG]) begin
         shortFlag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (clear) begin
         thermFlag_r <= 1'b0;
      end else if (thermStable) begin
         thermFlag_r <= 1'b1;
      end else if (funcWr && !wrData[BIT_THERMAL_FLAG]) begin
         thermFlag_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // control outputs
   // ----------------------------------------------------------------
   logic [7:0] funcReg;
   assign funcReg = regFile[0];

   always_ff @(posedge clk) begin
      if (clear) begin
         ampActive       <= 1'b0;
         coreRun         <= 1'b0;
         noiseGateActive <= 1'b0;
      end else begin
         // the live condition gates, not the latched flag
         ampActive <= funcReg[BIT_AMP_EN] && !thermStable
                      && !funcReg[BIT_SOFT_SHUTDOWN];
         coreRun   <= !funcReg[BIT_SOFT_SHUTDOWN];
         noiseGateActive <= funcReg[BIT_NOISE_GATE_ON]
                            && regFile[6][1:0] != RATIO_ONE_TO_ONE;
      end
   end

   assign attackStepCode  = regFile[1][CODE_MSB:0];
   assign releaseStepCode = regFile[2][CODE_MSB:0];
   assign holdCode        = regFile[3][CODE_MSB:0];
   assign presetGainCode  = regFile[4][CODE_MSB:0];
   assign limiterGateCfg  = regFile[5];
   assign maxGainRatioCfg = regFile[6];

   // ----------------------------------------------------------------
   // gain step interval timers: tick every code * unit cycles
   // ----------------------------------------------------------------
   logic [1:0] tick_r;

   generate
      for (genvar t = 0; t < 2; t++) begin : g_timer
         localparam int UNIT = (t == 0) ? ATTACK_UNIT : RELEASE_UNIT;
         logic [UNIT_CNT_W-1:0] unit_r;
         logic [5:0]            steps_r;
         logic [5:0]            code;
         logic                  unitDone;
         assign code     = (t == 0) ? attackStepCode : releaseStepCode;
         assign unitDone = unit_r == UNIT_CNT_W'(UNIT - 1);
         always_ff @(posedge clk) begin
            if (clear || !coreRun) begin
               unit_r  <= '0;
               steps_r <= 6'h00;
               tick_r[t] <= 1'b0;
            end else begin
               tick_r[t] <= 1'b0;
               unit_r    <= unitDone ? '0 : unit_r + 1'b1;
               if (unitDone) begin
                  // code zero behaves as one step
                  if (steps_r + 6'h01 >= code) begin
                     steps_r   <= 6'h00;
                     tick_r[t] <= 1'b1;
                  end else begin
                     steps_r <= steps_r + 6'h01;
                  end
               end
            end
         end
      end
   endgenerate

   assign attackTick  = tick_r[0];
   assign releaseTick = tick_r[1];

endmodule
`default_nettype wire

// ---- verif/agc_amp_control_monitor.sv ----
/*
 * Port checker for the amplifier control register bank.
 * Assumes a bind from the testbench top and one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module agc_amp_control_monitor #(
   parameter int ATTACK_UNIT = 10
) (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       hwEnable,
   // serial and status
   input wire logic       scl,
   input wire logic       sdaOut,
   input wire logic       sdaOe,
   input wire logic       overTemp,
   // control outputs
   input wire logic       ampActive,
   input wire logic       coreRun,
   input wire logic       noiseGateActive,
   input wire logic [5:0] attackStepCode,
   input wire logic [5:0] releaseStepCode,
   input wire logic [5:0] holdCode,
   input wire logic [5:0] presetGainCode,
   input wire logic [7:0] limiterGateCfg,
   input wire logic [7:0] maxGainRatioCfg,
   input wire logic       attackTick,
   input wire logic       releaseTick
);
   // gap between ticks; only trusted once a tick starts a clean interval
   logic [15:0] gap_r;
   logic        gapOk_r;
   logic [15:0] atkPeriod;
   assign atkPeriod = 16'((attackStepCode == 6'h00 ? 1 : attackStepCode) * ATTACK_UNIT);
   always_ff @(posedge clk) begin
      if (!rst_n || !coreRun || $changed(attackStepCode)) begin
         gapOk_r <= 1'b0;
         gap_r   <= 16'h0000;
      end else if (attackTick) begin
         gapOk_r <= 1'b1;
         gap_r   <= 16'h0001;
      end else begin
         gap_r <= gap_r + 16'h0001;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ----------
   // properties
   // ----------
   property p_sda_phase; $changed(sdaOe) |-> !scl && !sdaOut; endproperty
   a_sda_phase: assert property (p_sda_phase) else $error("sda moved while scl high");
   property p_defaults;
      $rose(rst_n) && hwEnable |-> attackStepCode == 6'h05 && releaseStepCode == 6'h0B
         && holdCode == 6'h00 && presetGainCode == 6'h06 && limiterGateCfg == 8'h3A
         && maxGainRatioCfg == 8'hC2;
   endproperty
   a_defaults: assert property (p_defaults) else $error("bad values after reset");
   property p_shut; !coreRun |-> !ampActive; endproperty
   a_shut: assert property (p_shut) else $error("amp active in shutdown");
   property p_therm_off; overTemp [*4] |=> !ampActive; endproperty
   a_therm_off: assert property (p_therm_off) else $error("amp active while hot");
   property p_therm_back;
      ampActive ##1 overTemp [*4] ##1 (!overTemp) [*3] |-> ampActive;
   endproperty
   a_therm_back: assert property (p_therm_back) else $error("amp not back after cooling");
   property p_ratio; noiseGateActive |-> $past(maxGainRatioCfg[1:0]) != 2'b00; endproperty
   a_ratio: assert property (p_ratio) else $error("gate on at unity ratio");
   property p_hw_reset;
      !hwEnable |=> !ampActive && !coreRun && !sdaOe && attackStepCode == 6'h05;
   endproperty
   a_hw_reset: assert property (p_hw_reset) else $error("enable pin did not reset");
   property p_atk_gap; attackTick && gapOk_r |-> gap_r == atkPeriod; endproperty
   a_atk_gap: assert property (p_atk_gap) else $error("attack tick spacing wrong");
   property p_rel_quiet; releaseTick |=> (!releaseTick) [*8]; endproperty
   a_rel_quiet: assert property (p_rel_quiet) else $error("release ticks too close");
   c_tick: cover property (attackTick && gapOk_r);
   c_gate: cover property ($rose(noiseGateActive));
   c_hot: cover property (coreRun && !ampActive);
   c_ack: cover property ($rose(sdaOe));
endmodule
`default_nettype wire

// ---- verif/i2c_host_model.sv ----
/*
 * Two-wire serial host model: start, stop, byte transfers.
 * Assumes the testbench resolves sda with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
   // clock
   input  wire logic clk,
   // bus
   input  wire logic sda,
   output logic      scl,
   output logic      sdaPull
);
   logic ackAll;
   initial begin
      scl     = 1'b1;
      sdaPull = 1'b0;
      ackAll  = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask
   // six cycles per scl level, above the two the slave compares (scl and its previous sample)
   task automatic bitIo(input logic b, output logic r);
      sdaPull = !b;
      hold(3);
      scl = 1'b1;
      hold(3);
      r = sda;
      hold(3);
      scl = 1'b0;
      hold(3);
   endtask
   task automatic start();
      sdaPull = 1'b0;
      hold(3);
      scl = 1'b1;
      hold(3);
      sdaPull = 1'b1;
      hold(3);
      scl = 1'b0;
      hold(3);
   endtask
   task automatic stop();
      sdaPull = 1'b1;
      hold(3);
      scl = 1'b1;
      hold(3);
      sdaPull = 1'b0;
      hold(3);
   endtask
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitIo(d[i], r);
      bitIo(1'b1, r);
      ack = !r;
   endtask
   task automatic writeRegs(input logic [7:0] ptr, input logic [7:0] q[$]);
      logic a;
      start();
      sendByte(8'hB0, a);
      ackAll &= a;
      sendByte(ptr, a);
      ackAll &= a;
      foreach (q[i]) begin
         sendByte(q[i], a);
         ackAll &= a;
      end
      stop();
   endtask
   task automatic readRegs(input logic [7:0] ptr, input int n, output logic [7:0] q[$]);
      logic       a;
      logic [7:0] d;
      start();
      sendByte(8'hB0, a);
      ackAll &= a;
      sendByte(ptr, a);
      ackAll &= a;
      start();
      sendByte(8'hB1, a);
      ackAll &= a;
      for (int i = 0; i < n; i++) begin
         for (int b = 7; b >= 0; b--) bitIo(1'b1, d[b]);
         bitIo(i == n - 1, a);
         q.push_back(d);
      end
      stop();
   endtask
endmodule
`default_nettype wire

// ---- verif/test_agc_amp_control_registers.sv ----
/*
 * Self-checking testbench for the register bank over the serial bus.
 * Assumes shortened timer units and deglitch count set at the instance.
 */
`timescale 1ns/1ps
`default_nettype none
module test_agc_amp_control_registers;
   localparam int         ATK = 10;
   localparam int         REL = 20;
   localparam logic [7:0] DFLT [7] = '{8'hC3, 8'h05, 8'h0B, 8'h00, 8'h06, 8'h3A, 8'hC2};
   localparam logic [7:0] WMAX [6] = '{8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'hFF, 8'hF3};
   localparam logic [5:0] TC [4]   = '{6'h00, 6'h01, 6'h03, 6'h02};
   logic       clk, rst_n, hwEnable, shortDetect, overTemp, scl, hostPull, sdaOut, sdaOe;
   logic       ampActive, coreRun, noiseGateActive, attackTick, releaseTick, a;
   logic [5:0] attackStepCode, releaseStepCode, holdCode, presetGainCode;
   logic [7:0] limiterGateCfg, maxGainRatioCfg;
   logic [15:0] n;
   logic [7:0] rq[$];
   wire        sdaWire;
   int         fail_count, total_checks;
   // pull-up: released line reads high
   assign sdaWire = ~(hostPull | (sdaOe & ~sdaOut));
   agc_amp_control_registers #(.RELEASE_UNIT(REL), .ATTACK_UNIT(ATK), .DEGLITCH(2))
   i_agc_amp_control_registers (
      .clk(clk), .rst_n(rst_n), .hwEnable(hwEnable), .scl(scl), .sdaIn(sdaWire),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .shortDetect(shortDetect), .overTemp(overTemp),
      .ampActive(ampActive), .coreRun(coreRun), .noiseGateActive(noiseGateActive),
      .attackStepCode(attackStepCode), .releaseStepCode(releaseStepCode),
      .holdCode(holdCode), .presetGainCode(presetGainCode),
      .limiterGateCfg(limiterGateCfg), .maxGainRatioCfg(maxGainRatioCfg),
      .attackTick(attackTick), .releaseTick(releaseTick));
   i2c_host_model i_i2c_host_model (.clk(clk), .sda(sdaWire), .scl(scl), .sdaPull(hostPull));
   always #20 clk = ~clk;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      i_i2c_host_model.writeRegs(p, '{d});
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      i_i2c_host_model.readRegs(p, 1, rq);
      chk(16'(rq[0]), 16'(e));
   endtask
   // skips the first tick, whose interval may straddle a code change
   task automatic tickGap(input logic sel, output logic [15:0] g);
      int w;
      w = 0;
      do begin @(negedge clk); w++; end while ((sel ? releaseTick : attackTick) !== 1'b1 && w < 3000);
      g = 16'h0000;
      do begin @(negedge clk); g++; end while ((sel ? releaseTick : attackTick) !== 1'b1 && g < 3000);
   endtask
   // -----------
   // scenarios
   // -----------
   initial begin
      {clk, rst_n, shortDetect, overTemp} = 4'h0;
      hwEnable = 1'b1;
      fail_count = 0;
      total_checks = 0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      i_i2c_host_model.readRegs(8'h01, 7, rq);
      foreach (DFLT[i]) chk(16'(rq[i]), 16'(DFLT[i]));
      chk(16'({ampActive, coreRun, noiseGateActive}), 16'h0007);
      $display("test defaults over");
      i_i2c_host_model.writeRegs(8'h02, '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
      i_i2c_host_model.readRegs(8'h02, 6, rq);
      foreach (WMAX[i]) chk(16'(rq[i]), 16'(WMAX[i]));
      chk(16'(maxGainRatioCfg), 16'h00F3);
      hwEnable = 1'b0;
      repeat (2) @(negedge clk);
      hwEnable = 1'b1;
      repeat (2) @(negedge clk);
      rd(8'h02, 8'h05);
      rd(8'h07, 8'hC2);
      $display("test sequential write over");
      wr(8'h01, 8'hFF);
      rd(8'h01, 8'hE3);
      chk(16'({coreRun, ampActive}), 16'h0000);
      wr(8'h01, 8'h83);
      chk(16'({coreRun, ampActive}), 16'h0002);
      wr(8'h01, 8'hC3);
      chk(16'(ampActive), 16'h0001);
      shortDetect = 1'b1;
      @(negedge clk);
      shortDetect = 1'b0;
      rd(8'h01, 8'hCB);
      wr(8'h01, 8'hCB);
      rd(8'h01, 8'hCB);
      wr(8'h01, 8'hC3);
      rd(8'h01, 8'hC3);
      overTemp = 1'b1;
      @(negedge clk);
      overTemp = 1'b0;
      rd(8'h01, 8'hC3);
      overTemp = 1'b1;
      repeat (6) @(negedge clk);
      chk(16'(ampActive), 16'h0000);
      overTemp = 1'b0;
      repeat (3) @(negedge clk);
      chk(16'(ampActive), 16'h0001);
      rd(8'h01, 8'hC7);
      wr(8'h01, 8'hC3);
      rd(8'h01, 8'hC3);
      $display("test function control over");
      for (int r = 0; r < 4; r++) begin
         wr(8'h07, 8'hC0 | 8'(r));
         chk(16'(noiseGateActive), 16'(r != 0));
      end
      wr(8'h01, 8'hC2);
      chk(16'(noiseGateActive), 16'h0000);
      wr(8'h01, 8'hC3);
      $display("test noise gate over");
      for (int i = 0; i < 4; i++) begin
         wr(i == 3 ? 8'h03 : 8'h02, {2'b00, TC[i]});
         tickGap(i == 3, n);
         chk(n, 16'((TC[i] == 6'h00 ? 1 : TC[i]) * (i == 3 ? REL : ATK)));
      end
      $display("test step timers over");
      rd(8'h09, 8'h00);
      chk(16'(i_i2c_host_model.ackAll), 16'h0001);
      i_i2c_host_model.start();
      i_i2c_host_model.sendByte(8'hB2, a);
      i_i2c_host_model.stop();
      chk(16'(a), 16'h0000);
      $display("test addressing over");
      end_sim();
   end
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      end_sim();
   end
endmodule
bind agc_amp_control_registers agc_amp_control_monitor #(.ATTACK_UNIT(ATTACK_UNIT))
i_agc_amp_control_monitor (
   .clk(clk), .rst_n(rst_n), .hwEnable(hwEnable), .scl(scl), .sdaOut(sdaOut),
   .sdaOe(sdaOe), .overTemp(overTemp), .ampActive(ampActive), .coreRun(coreRun),
   .noiseGateActive(noiseGateActive), .attackStepCode(attackStepCode),
   .releaseStepCode(releaseStepCode), .holdCode(holdCode), .presetGainCode(presetGainCode),
   .limiterGateCfg(limiterGateCfg), .maxGainRatioCfg(maxGainRatioCfg),
   .attackTick(attackTick), .releaseTick(releaseTick));
`default_nettype wire
